/* hw/grp_pkg.sv */
// constants for the gpio / respiration / pace port block
// assumes a 100 MHz system clock and an apb register bus
package grp_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    // register byte offsets
    localparam logic [7:0]  OFS_GPIO        = 8'h00;
    localparam logic [7:0]  OFS_PACE        = 8'h04;
    localparam logic [7:0]  OFS_RESPIRATION_CONTROL_REG        = 8'h08;
    localparam logic [7:0]  OFS_CFG4        = 8'h0C;
    localparam logic [7:0]  OFS_STAT        = 8'h10;
    // gpio register fields: direction [3:0] (1 = input), level [7:4]
    localparam int unsigned GPIO_DIR_LSB    = 0;
    localparam int unsigned GPIO_LVL_LSB    = 4;
    localparam logic [3:0]  GPIO_DIR_RST    = 4'hF;
    // pace register fields
    localparam int unsigned PACE_PD_BIT     = 0;
    localparam int unsigned PACE_ODD_LSB    = 1;
    localparam int unsigned PACE_EVEN_LSB   = 3;
    // respiration control register fields
    localparam int unsigned RESPIRATION_CONTROL_REG_MODE_LSB   = 0;
    localparam int unsigned DEMOD_PHASE_FIELD_LSB     = 2;
    localparam int unsigned RESPIRATION_CONTROL_REG_DEMOD_BIT  = 5;
    localparam int unsigned RESPIRATION_CONTROL_REG_MOD_BIT    = 6;
    // config register four: modulation rate field [7:5]
    localparam int unsigned CFG4_RATE_LSB   = 5;
    localparam logic [2:0]  RATE_64K        = 3'h0;
    localparam logic [2:0]  RATE_32K        = 3'h1;
    // respiration modes
    localparam logic [1:0]  MODE_OFF        = 2'h0;
    localparam logic [1:0]  MODE_EXT        = 2'h1;
    localparam logic [1:0]  MODE_INT        = 2'h2;
    localparam logic [1:0]  MODE_USER       = 2'h3;
    // modulation nco: 32-bit accumulator, step for 64 kHz
    localparam longint unsigned MOD_HZ      = 64_000;
    localparam logic [31:0] NCO_STEP_64K    = 32'((MOD_HZ * 64'h1_0000_0000) / CLK_HZ);
    // one phase step is 22.5 degrees, 1/16 of a turn
    localparam logic [31:0] PHASE_STEP      = 32'h1000_0000;
    // pin snapshot lead ahead of conversion-done falling edge
    localparam int unsigned SNAP_LEAD_CYC   = 2;
    // oscillator and reference wake time after powerdown release
    localparam int unsigned WAKE_TIME_NS    = 100_000;
    localparam int unsigned WAKE_CYC        = (WAKE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
endpackage : grp_pkg

/* hw/grp_port.sv */
// gpio port with respiration clock generation and pace control, apb slave
// assumes synchronous pins, one 100 MHz clock, a conversion strobe from the adc core
//
// Function
// RULE1 - pin levels latched two clocks before conversion-done falls
// RULE2 - pace select bits 4..1 route one odd and one even channel
// RULE3 - pace powerdown bit turns both pace amplifiers off
// RULE4 - pace amplifier outputs share the positive and negative test pins
// RULE5 - two-bit respiration field picks off, external, internal or user mode
// RULE6 - base variants accept only off and external respiration modes
// RULE7 - host must not pick user mode while internal oscillator selected
// RULE8 - external mode forces gpio2..4 to outputs, overriding general use
// RULE9 - external mode drives modulation gpio3, demodulation gpio4, xor gpio2
// RULE10 - rate field selects 64 or 32 kHz; other codes give squares only
// RULE11 - phase field sets demodulation lag 22.5 to 157.5 degrees
// RULE12 - internal mode: enable bits gate modulator and demodulator; gpio stays free
// RULE13 - internal mode reserves channel 1 for respiration, no ecg data
// RULE14 - user mode forces gpio2..4 to inputs carrying blocking, mod, demod
// RULE15 - each gpio pin has its own direction bit
// RULE16 - reading level bits returns real pin levels
// RULE17 - level write sets output pins only, ignored for input pins
// RULE18 - all gpio pins are inputs after reset
// RULE19 - outside party drives every input pin, never floating
// RULE20 - powerdown pin low stops everything; rise resumes after wake time
// RULE21 - outside party should stop the master clock during powerdown
// RULE22 - clock select pin: low external clock, high internal oscillator
// RULE23 - external mode with other rate codes holds gpio2 low
`timescale 1ns/100ps
module grp_port #(
    parameter bit          HAS_RESPIRATION_CONTROL_REG_INT = 1'b1,
    parameter int unsigned WAKE_CYCLES  = grp_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // gpio pins, index 0 is gpio1
    input  wire logic [3:0]  i_gpio,
    output logic      [3:0]  o_gpio,
    output logic      [3:0]  o_gpio_oe,
    // device pins
    input  wire logic        i_clock_source_select_pin,
    input  wire logic        i_powerdown_n_pin,
    // conversion timing
    input  wire logic        i_conv_strobe,
    output logic             o_conversion_done_n,
    output logic      [3:0]  o_gpio_sample,
    // pace path control
    output logic      [1:0]  o_pace_odd_sel,
    output logic      [1:0]  o_pace_even_sel,
    output logic             o_pace_amp_on,
    output logic             o_test_pins_pace,
    // respiration control
    output logic             o_modulator_on,
    output logic             o_demodulator_on,
    output logic             o_modulation_out_pos,
    output logic             o_modulation_out_neg,
    output logic             o_demod_clk,
    output logic             o_blocking_signal,
    output logic             o_ch1_respiration_control_reg_only,
    // core power and clock
    output logic             o_core_on,
    output logic             o_use_internal_osc
);
    // register state
    logic [3:0]  dir_reg;
    logic [3:0]  lvl_reg;
    logic [4:0]  pace_reg;
    logic [6:0]  respiration_control_reg_reg;
    logic [2:0]  rate_reg;
    logic [31:0] nco_reg;
    logic [1:0]  snap_cnt_reg;
    logic [31:0] wake_cnt_reg;
    logic        awake_reg;
    logic        pd_prev_reg;

    // apb decode
    wire         setup_ph  = i_psel & ~i_penable;
    wire         acc_done  = i_psel & i_penable & o_pready;
    wire         wr_en     = acc_done & i_pwrite;
    wire         hit_gpio  = i_paddr == grp_pkg::OFS_GPIO;
    wire         hit_pace  = i_paddr == grp_pkg::OFS_PACE;
    wire         hit_respiration_control_reg  = i_paddr == grp_pkg::OFS_RESPIRATION_CONTROL_REG;
    wire         hit_cfg4  = i_paddr == grp_pkg::OFS_CFG4;
    wire         hit_stat  = i_paddr == grp_pkg::OFS_STAT;
    wire         mapped    = hit_gpio | hit_pace | hit_respiration_control_reg | hit_cfg4 | hit_stat;

    // effective respiration mode; internal modes absent on base variant
    wire [1:0]   mode_raw  = respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_MODE_LSB +: 2];
    wire [1:0]   mode      = (!HAS_RESPIRATION_CONTROL_REG_INT && mode_raw[1]) ? grp_pkg::MODE_OFF
                                                            : mode_raw; // RULE6 RULE5
    wire         m_ext     = awake_reg & (mode == grp_pkg::MODE_EXT);
    wire         m_int     = awake_reg & (mode == grp_pkg::MODE_INT);
    wire         m_user    = awake_reg & (mode == grp_pkg::MODE_USER);
    // host misuse flag, reported rather than blocked
    wire         bad_user  = m_user & i_clock_source_select_pin; // RULE7

    // nco: slower codes halve the step; xor only trusted at 64/32 kHz
    wire [31:0]  nco_step  = grp_pkg::NCO_STEP_64K >> rate_reg; // RULE10
    wire         rate_ok   = (rate_reg == grp_pkg::RATE_64K)
                           | (rate_reg == grp_pkg::RATE_32K); // RULE10
    wire [2:0]   ph_code   = respiration_control_reg_reg[grp_pkg::DEMOD_PHASE_FIELD_LSB +: 3];
    wire [2:0]   ph_clip   = (ph_code == 3'h7) ? 3'h6 : ph_code;
    wire [31:0]  ph_ofs    = grp_pkg::PHASE_STEP * 32'(ph_clip + 3'h1); // RULE11
    wire [31:0]  demod_acc = nco_reg - ph_ofs; // RULE11
    wire         mod_wave  = nco_reg[31];
    wire         dem_wave  = demod_acc[31];
    wire         run_nco   = m_ext | m_int;

    // gpio pin control
    wire [3:0]   force_out = {m_ext, m_ext, m_ext, 1'b0}; // RULE8
    wire [3:0]   force_in  = {m_user, m_user, m_user, 1'b0}; // RULE14
    wire [3:0]   gen_oe    = ~dir_reg & {4{awake_reg}}; // RULE15
    wire [3:0]   oe_next   = (gen_oe | force_out) & ~force_in; // RULE8 RULE14
    wire         xor_pin   = rate_ok & (mod_wave ^ dem_wave); // RULE9 RULE23
    wire [3:0]   out_next  = m_ext ? {dem_wave, mod_wave, xor_pin, lvl_reg[0]}
                                   : lvl_reg; // RULE9
    // level write lands only on output pins
    wire [3:0]   lvl_wr    = i_pwdata[grp_pkg::GPIO_LVL_LSB +: 4];
    wire [3:0]   dir_wr    = i_pwdata[grp_pkg::GPIO_DIR_LSB +: 4];
    wire [3:0]   lvl_next  = (lvl_wr & ~dir_reg) | (lvl_reg & dir_reg); // RULE17

    // read mux; gpio level field shows the pins, not the latch
    wire [31:0]  rd_gpio   = {24'h0, i_gpio, dir_reg}; // RULE16
    wire [31:0]  rd_stat   = {25'h0, bad_user, i_clock_source_select_pin,
                              awake_reg, o_gpio_sample[3:1], 1'b0};
    wire [31:0]  rd_next   = hit_gpio ? rd_gpio
                           : hit_pace ? {27'h0, pace_reg}
                           : hit_respiration_control_reg ? {25'h0, respiration_control_reg_reg}
                           : hit_cfg4 ? {24'h0, rate_reg, 5'h0}
                           : hit_stat ? rd_stat
                           : 32'h0;

    // conversion-done timing
    wire         snap_now  = i_conv_strobe & awake_reg;
    wire         conversion_done_n_fall = snap_cnt_reg == 2'h1;

    // powerdown and wake
    wire         pd_rise   = i_powerdown_n_pin & ~pd_prev_reg;

    // apb response
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end else begin
            o_pready  <= setup_ph;
            o_pslverr <= setup_ph & ~mapped;
            o_prdata  <= setup_ph ? rd_next : o_prdata;
        end
    end

    // software registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            dir_reg  <= grp_pkg::GPIO_DIR_RST; // RULE18
            lvl_reg  <= 4'h0;
            pace_reg <= 5'h0;
            respiration_control_reg_reg <= 7'h0;
            rate_reg <= grp_pkg::RATE_64K;
        end else if (wr_en) begin
            if (hit_gpio) begin
                dir_reg <= dir_wr; // RULE15
                lvl_reg <= lvl_next; // RULE17
            end
            if (hit_pace) begin
                pace_reg <= i_pwdata[4:0];
            end
            if (hit_respiration_control_reg) begin
                respiration_control_reg_reg <= i_pwdata[6:0];
            end
            if (hit_cfg4) begin
                rate_reg <= i_pwdata[grp_pkg::CFG4_RATE_LSB +: 3];
            end
        end
    end

    // modulation nco, cleared to zero outside the generating modes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            nco_reg <= 32'h0;
        end else begin
            nco_reg <= run_nco ? nco_reg + nco_step : 32'h0;
        end
    end

    // pins and respiration outputs
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_gpio_oe            <= 4'h0; // RULE18
            o_gpio               <= 4'h0;
            o_modulator_on       <= 1'b0;
            o_demodulator_on     <= 1'b0;
            o_modulation_out_pos <= 1'b0;
            o_modulation_out_neg <= 1'b0;
            o_demod_clk          <= 1'b0;
            o_blocking_signal    <= 1'b0;
            o_ch1_respiration_control_reg_only      <= 1'b0;
        end else begin
            o_gpio_oe            <= oe_next;
            o_gpio               <= out_next;
            o_modulator_on       <= m_int & respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_MOD_BIT]; // RULE12
            o_demodulator_on     <= m_int & respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_DEMOD_BIT]; // RULE12
            o_modulation_out_pos <= m_int & respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_MOD_BIT] & mod_wave;
            o_modulation_out_neg <= m_int & respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_MOD_BIT] & ~mod_wave;
            // user mode takes blocking from gpio2 and demod from gpio4; gpio3 is not used
            o_demod_clk          <= m_user ? i_gpio[3]
                                  : (m_int & respiration_control_reg_reg[grp_pkg::RESPIRATION_CONTROL_REG_DEMOD_BIT] & dem_wave);
            o_blocking_signal    <= m_user & i_gpio[1]; // RULE14
            o_ch1_respiration_control_reg_only      <= m_int; // RULE13
        end
    end

    // pace amplifiers share the test pins; off in powerdown too
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_pace_odd_sel     <= 2'h0;
            o_pace_even_sel    <= 2'h0;
            o_pace_amp_on      <= 1'b0;
            o_test_pins_pace   <= 1'b0;
            o_use_internal_osc <= 1'b0;
        end else begin
            o_pace_odd_sel     <= pace_reg[grp_pkg::PACE_ODD_LSB +: 2]; // RULE2
            o_pace_even_sel    <= pace_reg[grp_pkg::PACE_EVEN_LSB +: 2]; // RULE2
            o_pace_amp_on      <= awake_reg & ~pace_reg[grp_pkg::PACE_PD_BIT]; // RULE3
            o_test_pins_pace   <= awake_reg & ~pace_reg[grp_pkg::PACE_PD_BIT]; // RULE4
            o_use_internal_osc <= i_clock_source_select_pin; // RULE22
        end
    end

    // pin snapshot then conversion-done falls after the lead time
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            snap_cnt_reg        <= 2'h0;
            o_gpio_sample       <= 4'h0;
            o_conversion_done_n <= 1'b1;
        end else begin
            if (snap_now) begin
                snap_cnt_reg  <= 2'(grp_pkg::SNAP_LEAD_CYC); // RULE1
                o_gpio_sample <= i_gpio; // RULE1
            end else if (snap_cnt_reg != 2'h0) begin
                snap_cnt_reg  <= snap_cnt_reg - 2'h1;
            end
            // high again at the next strobe, low once the lead expires
            if (snap_now || !awake_reg) begin
                o_conversion_done_n <= 1'b1;
            end else if (conversion_done_n_fall) begin
                o_conversion_done_n <= 1'b0; // RULE1
            end
        end
    end

    // powerdown: everything off while low, wake delay after release
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pd_prev_reg  <= 1'b0;
            wake_cnt_reg <= 32'h0;
            awake_reg    <= 1'b0;
            o_core_on    <= 1'b0;
        end else begin
            pd_prev_reg <= i_powerdown_n_pin;
            if (!i_powerdown_n_pin) begin
                awake_reg    <= 1'b0; // RULE20
                wake_cnt_reg <= 32'h0;
            end else if (pd_rise) begin
                wake_cnt_reg <= 32'(WAKE_CYCLES); // RULE20
            end else if (wake_cnt_reg > 32'h1) begin
                wake_cnt_reg <= wake_cnt_reg - 32'h1;
            end else if (!awake_reg) begin
                awake_reg    <= 1'b1; // RULE20
                wake_cnt_reg <= 32'h0;
            end
            o_core_on <= awake_reg & i_powerdown_n_pin;
        end
    end

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    chk_snap_lead_two: assert property ( // RULE1
        snap_now ##1 !snap_now [*2] |=> $fell(o_conversion_done_n))
        else $error("conversion done did not fall two clocks after snapshot");
    chk_snap_pins_held: assert property ( // RULE1
        snap_now |=> o_gpio_sample == $past(i_gpio))
        else $error("pin snapshot mismatch");
    chk_pace_sel_route: assert property ( // RULE2
        wr_en && hit_pace |-> ##2 o_pace_odd_sel == $past(i_pwdata[2:1], 2))
        else $error("pace odd select not applied");
    chk_pace_pd_off: assert property ( // RULE3
        pace_reg[0] |=> !o_pace_amp_on && !o_test_pins_pace)
        else $error("pace amplifier on while powered down");
    chk_ext_mode_out: assert property ( // RULE8
        m_ext |=> o_gpio_oe[3:1] == 3'h7)
        else $error("external mode pins not outputs");
    chk_ext_xor_pin: assert property ( // RULE9
        m_ext && rate_ok |=> o_gpio[1] == (o_gpio[2] ^ o_gpio[3]))
        else $error("gpio2 is not xor of modulation and demodulation");
    chk_bad_rate_low: assert property ( // RULE23
        m_ext && !rate_ok |=> !o_gpio[1])
        else $error("gpio2 not held low at unsupported rate");
    chk_user_inputs: assert property ( // RULE14
        m_user |=> o_gpio_oe[3:1] == 3'h0)
        else $error("user mode pins still driven");
    chk_int_ch1_busy: assert property ( // RULE13
        m_int |=> o_ch1_respiration_control_reg_only)
        else $error("channel 1 not reserved in internal mode");
    chk_level_ignored: assert property ( // RULE17
        wr_en && hit_gpio && dir_reg[0] |=> lvl_reg[0] == $past(lvl_reg[0]))
        else $error("level write changed an input pin");
    chk_reset_inputs: assert property ( // RULE18
        $rose(i_rst_n) |-> o_gpio_oe == 4'h0 && dir_reg == 4'hF)
        else $error("gpio not inputs after reset");
    chk_powerdown_n_pin_all_off: assert property ( // RULE20
        !i_powerdown_n_pin |=> !awake_reg ##1 !o_core_on && o_gpio_oe == 4'h0)
        else $error("circuitry active during powerdown");
    chk_base_no_int: assert property ( // RULE6
        !HAS_RESPIRATION_CONTROL_REG_INT |-> !m_int && !m_user)
        else $error("internal respiration on base variant");

    cov_ext_mode: cover property (m_ext && rate_ok ##1 o_gpio[1]);
    cov_user_mode: cover property (m_user);
    cov_conversion_done_n_fall: cover property ($fell(o_conversion_done_n));
    cov_wake_up: cover property ($rose(awake_reg));
endmodule : grp_port

/* test/grp_far_end.sv */
// far-side model: pace detector and respiration signal source on the gpio pins
// assumes the port block's clock; pins have no pull, so every pin is driven
`timescale 1ns/100ps
module grp_far_end (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // control from the bench
    input  wire logic       i_user_mode,
    input  wire logic [3:0] i_pattern,
    // pin drive, index 0 is gpio1
    output logic      [3:0] o_drive
);
    logic [6:0] cnt_reg;
    logic [6:0] lag_w;
    always_ff @(posedge i_clk_sys) begin
        cnt_reg <= i_rst_n ? cnt_reg + 7'h01 : 7'h00;
    end
    // demod trails mod by 8 of 64 cycles, 45 degrees
    assign lag_w   = cnt_reg - 7'h08;
    // blocking on gpio2, mod on gpio3, demod on gpio4; pace level on gpio1
    assign o_drive = i_user_mode ? {lag_w[5], cnt_reg[5], cnt_reg[6], i_pattern[0]}
                                 : i_pattern;
endmodule : grp_far_end

/* test/testbench.sv */
// self-checking bench for the gpio / respiration / pace port
// assumes grp_port over apb and the far-side model driving the gpio pins
`timescale 1ns/100ps
module testbench;
    localparam int unsigned WAKE = 8;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, done_n, amp_on, mod_on, demod_on, blk, dclk, ch1;
    logic        core_on, int_osc, clk_sel = 1'b0, powerdown_n_pin_n = 1'b1, conv = 1'b0, user = 1'b0;
    logic [3:0]  pat = 4'h0, ext, gpio_out, gpio_oe, pins, gsample, d, l, p;
    logic [1:0]  odd, even, e;
    logic [4:0]  v;
    logic [2:0]  h, g;
    logic        xor_on = 1'b0, tp_on, mpos, mneg;
    int          mismatches = 0, num_checks = 0, cyc = 0, xmis = 0, n, k;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    assign pins = (gpio_oe & gpio_out) | (~gpio_oe & ext);

    grp_port #(.HAS_RESPIRATION_CONTROL_REG_INT(1'b1), .WAKE_CYCLES(WAKE)) i_grp_port (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_gpio(pins), .o_gpio(gpio_out),
        .o_gpio_oe(gpio_oe), .i_clock_source_select_pin(clk_sel),
        .i_powerdown_n_pin(powerdown_n_pin_n), .i_conv_strobe(conv), .o_conversion_done_n(done_n),
        .o_gpio_sample(gsample), .o_pace_odd_sel(odd), .o_pace_even_sel(even),
        .o_pace_amp_on(amp_on), .o_test_pins_pace(tp_on), .o_modulator_on(mod_on),
        .o_demodulator_on(demod_on), .o_modulation_out_pos(mpos),
        .o_modulation_out_neg(mneg),
        .o_demod_clk(dclk), .o_blocking_signal(blk), .o_ch1_respiration_control_reg_only(ch1),
        .o_core_on(core_on), .o_use_internal_osc(int_osc));
    grp_far_end i_grp_far_end (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_user_mode(user),
        .i_pattern(pat), .o_drive(ext));

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : tick
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int c;
        c = 0;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin @(posedge clk_sys); c++; end while (pready !== 1'b1 && c < 16);
        if (c >= 16) begin mismatches++; final_report(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_on;
        n = 0;
        while (core_on !== 1'b1 && n < 64) begin @(posedge clk_sys); n++; end
        if (n >= 64) begin mismatches++; final_report(); end
    endtask : wait_on
    function automatic logic [3:0] exp_pins(input logic [3:0] dr, lv, ex);
        return (dr & ex) | (~dr & lv);
    endfunction : exp_pins
    function automatic logic [31:0] in_rng(input int x, lo, hi);
        return {31'h0, x >= lo && x <= hi};
    endfunction : in_rng
    // period rounds down: 64 kHz is 1562.5 cycles
    function automatic int exp_per(input logic [2:0] rate);
        return (grp_pkg::CLK_HZ / 64000) << rate;
    endfunction : exp_per
    task automatic rise(input int idx, output int t);
        logic q;
        int c;
        q = gpio_out[idx];
        c = 0;
        while (c < 20000) begin
            @(posedge clk_sys);
            c++;
            if (gpio_out[1] !== (xor_on ? gpio_out[2] ^ gpio_out[3] : 1'b0)) xmis++;
            if (q === 1'b0 && gpio_out[idx] === 1'b1) break;
            q = gpio_out[idx];
        end
        if (c >= 20000) begin mismatches++; final_report(); end
        t = cyc;
    endtask : rise
    // one registered cycle of xor slip per edge is tolerated
    task automatic respiration_control_reg_meas(input logic [2:0] rate, input logic xon);
        int t0, t1, t2;
        apb(1'b1, grp_pkg::OFS_CFG4, {24'h0, rate, 5'h0});
        apb(1'b1, grp_pkg::OFS_RESPIRATION_CONTROL_REG, 32'(k << 2) | 32'h1);
        xor_on = xon;
        rise(2, t0);
        xmis = 0;
        rise(3, t1);
        rise(2, t2);
        check(gpio_oe[3:1], 3'h7);
        check(in_rng(t2 - t0, exp_per(rate) - 2, exp_per(rate) + 2), 1);
        check(in_rng(t1 - t0, (t2 - t0) * (k + 1) / 16 - 3, (t2 - t0) * (k + 1) / 16 + 3), 1);
        check(in_rng(xmis, 0, 4), 1);
    endtask : respiration_control_reg_meas

    initial begin
        void'($urandom(65589));
        repeat (8) @(posedge clk_sys);
        check(gpio_oe, 4'h0);
        rst_n <= 1'b1;
        wait_on();
        apb(1'b0, grp_pkg::OFS_GPIO, 32'h0);
        check(rd[3:0], grp_pkg::GPIO_DIR_RST);
        check(gpio_oe, 4'h0);
        apb(1'b0, 8'h14, 32'h0);
        check({rd[30:0], err}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
            l = 4'($urandom);
            pat <= 4'($urandom);
            apb(1'b1, grp_pkg::OFS_GPIO, {24'h0, l, d});
            apb(1'b1, grp_pkg::OFS_GPIO, {24'h0, l, d});
            apb(1'b0, grp_pkg::OFS_GPIO, 32'h0);
            check(gpio_oe, 4'(~d));
            check(4'(gpio_out & ~d), 4'(l & ~d));
            check(rd[7:4], exp_pins(d, l, pat));
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
            apb(1'b1, grp_pkg::OFS_PACE, {27'h0, v});
            tick(2);
            check(odd, v[2:1]);
            check(even, v[4:3]);
            check(amp_on, !v[0]);
            check(tp_on, !v[0]);
        end
        apb(1'b1, grp_pkg::OFS_GPIO, 32'h0F);
        k = $urandom_range(6, 0);
        respiration_control_reg_meas(grp_pkg::RATE_64K, 1'b1);
        respiration_control_reg_meas(grp_pkg::RATE_32K, 1'b1);
        respiration_control_reg_meas(3'h2, 1'b0);
        apb(1'b1, grp_pkg::OFS_GPIO, 32'h05);
        for (int i = 0; i < 4; i++) begin
            e = 2'(i);
            apb(1'b1, grp_pkg::OFS_RESPIRATION_CONTROL_REG, {25'h0, e, 3'h0, grp_pkg::MODE_INT});
            tick(2);
            check(ch1, 1'b1);
            check({mod_on, demod_on}, e);
            check(mpos ^ mneg, e[1]);
            check(gpio_oe, 4'hA);
        end
        apb(1'b1, grp_pkg::OFS_RESPIRATION_CONTROL_REG, 32'h0);
        tick(2);
        check({ch1, mod_on, demod_on}, 3'h0);
        // external clock kept selected for user mode
        user <= 1'b1;
        apb(1'b1, grp_pkg::OFS_RESPIRATION_CONTROL_REG, {30'h0, grp_pkg::MODE_USER});
        apb(1'b1, grp_pkg::OFS_GPIO, 32'h00);
        tick(2);
        check(gpio_oe[3:1], 3'h0);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            h = {h[1:0], pins[1]};
            g = {g[1:0], pins[3]};
            if (i > 3 && (h == 3'h0 || h == 3'h7)) check(blk, h[0]);
            if (i > 3 && (g == 3'h0 || g == 3'h7)) check(dclk, g[0]);
        end
        user <= 1'b0;
        apb(1'b1, grp_pkg::OFS_RESPIRATION_CONTROL_REG, 32'h0);
        apb(1'b1, grp_pkg::OFS_GPIO, 32'h0F);
        p = 4'($urandom);
        pat <= p;
        tick(3);
        conv <= 1'b1;
        @(posedge clk_sys);
        conv <= 1'b0;
        pat <= ~p;
        tick(2);
        check(gsample, p);
        check(done_n, 1'b1);
        tick(1);
        check(done_n, 1'b0);
        clk_sel <= 1'b1;
        tick(3);
        check(int_osc, 1'b1);
        apb(1'b0, grp_pkg::OFS_STAT, 32'h0);
        check(rd[5], 1'b1);
        clk_sel <= 1'b0;
        apb(1'b1, grp_pkg::OFS_GPIO, 32'h00);
        // clock left running: the block must power down regardless
        powerdown_n_pin_n <= 1'b0;
        tick(4);
        check({core_on, gpio_oe}, 5'h00);
        powerdown_n_pin_n <= 1'b1;
        wait_on();
        check(in_rng(n, WAKE, WAKE + 4), 1);
        final_report();
    end
endmodule : testbench
